// ===== hw/acsr_map.vh
// Register map and timing counts of the serial register block.
`ifndef ACSR_MAP_VH
`define ACSR_MAP_VH
`define ACSR_ADDR_W 4
`define ACSR_TIMER_STATE_REPORT 4'h0
`define ACSR_MODEM_PIN_REPORT 4'h1
`define ACSR_DEVICE_COMMAND 4'h2
`define ACSR_TRANSMITTER_COMMAND 4'h3
`define ACSR_RECEIVER_COMMAND 4'h4
`define ACSR_TIMER_GATE_AND_START 4'h5
`define ACSR_MODEM_OUTPUT_CONTROL 4'h6
`define ACSR_TRANSMIT_BYTE 4'h7
`define ACSR_TRANSMIT_EXTRA_BITS 4'h8
`define ACSR_RECEIVE_BYTE 4'h9
`define ACSR_RECEIVE_CHAR_FLAGS 4'hA
`define ACSR_GROUP_STATUS 4'hB
// device_command bits
`define ACSR_SOFTWARE_TOTAL_RESET 0
`define ACSR_IRQ_ACKNOWLEDGE_CMD 1
`define ACSR_STATUS_WIPE_CMD 2
`define ACSR_POWER_DOWN_CMD 3
// transmitter_command bits
`define ACSR_FLUSH_TRANSMITTER_CMD 0
`define ACSR_FLUSH_TX_QUEUE_CMD 1
`define ACSR_TRANSMIT_ENABLE_CMD 2
`define ACSR_TRANSMIT_DISABLE_CMD 3
// receiver_command bits
`define ACSR_RECEIVE_ENABLE_CMD 0
`define ACSR_RECEIVE_DISABLE_CMD 1
`define ACSR_FLUSH_RECEIVER_CMD 2
`define ACSR_FLUSH_RX_QUEUE_CMD 3
`define ACSR_LOCK_RX_QUEUE_CMD 4
`define ACSR_UNLOCK_RX_QUEUE_CMD 5
// timer_gate_and_start bits
`define ACSR_TIMER_A_GATE 0
`define ACSR_TIMER_B_GATE 1
`define ACSR_TIMER_A_START_CMD 2
`define ACSR_TIMER_B_START_CMD 3
// modem_output_control bits
`define ACSR_DTR_BIT 0
`define ACSR_RTS_BIT 1
`define ACSR_GENERAL_OUTPUT_ONE 2
`define ACSR_GENERAL_OUTPUT_TWO 3
`define ACSR_LOOPBACK_SELECT_BIT 4
`define ACSR_GENERAL_OUTPUT_ZERO 5
`define ACSR_MODEM_OUTPUT_RESET 8'h00
`define ACSR_EXTRA_BITS_RESET 3'h0
// Timing counts in clocks.
`define ACSR_SOFT_RESET_CLOCKS 3'h4
`define ACSR_IRQ_ACK_CLOCKS 2'h2
`endif

// ===== hw/acsr_fifo.v
// Synchronous valid/ready FIFO with a flush input.
`timescale 1ns/1ns
module acsr_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign level = count;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ===== hw/acsr_regs.v
// Command, status, modem-control and data registers of the asynchronous serial controller.
//
// Contract
// RQ1 - Timer terminal count sets expired bit, requests irq.
// RQ2 - Gate state bits shown, never raise interrupts.
// RQ3 - Low four modem bits feed modem irq.
// RQ4 - Reading modem pin report clears change bits.
// RQ5 - Inverted DCD, RI, DSR only for inputs.
// RQ6 - DCD, DSR, CTS changes set delta bits.
// RQ7 - Only falling RI edge sets ring bit.
// RQ8 - Command registers write-only, bits self-clear.
// RQ9 - Host sets one command bit per write.
// RQ10 - Software reset: four clocks, keeps straps.
// RQ11 - Interrupt acknowledge holds irq low two clocks.
// RQ12 - Status wipe clears status; power down mode.
// RQ13 - Transmit flush, queue flush and enable commands.
// RQ14 - Disable waits for current character to finish.
// RQ15 - Receive flush, queue flush, enable, disable commands.
// RQ16 - Lock discards received characters; unlock restores.
// RQ17 - Gates ignored in baud mode; gates persist.
// RQ18 - Start command triggers timer; count sets expired.
// RQ19 - Modem outputs inverted, only on general outputs.
// RQ20 - Loopback bit enters loopback, variant configured.
// RQ21 - Transmit byte write pushes byte with flags.
// RQ22 - Flags give address, parity, ninth bit.
// RQ23 - Receive byte holds oldest; read loads next.
// RQ24 - Receive flags load with receive byte.
`timescale 1ns/1ns
`include "acsr_map.vh"
module acsr_regs #(
  parameter TX_DEPTH = 32,
  parameter RX_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire clk,
  input wire rst,
  // Parallel register bus.
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire [`ACSR_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  output wire rdata_oe,
  // Timers.
  input wire timer_a_baud_mode,
  input wire timer_b_baud_mode,
  input wire timer_a_tc,
  input wire timer_b_tc,
  output reg timer_a_gate,
  output reg timer_b_gate,
  output reg timer_a_start,
  output reg timer_b_start,
  // Modem pins, active low at the package.
  input wire cts_n,
  input wire dcd_n,
  input wire dsr_n,
  input wire ri_n,
  input wire [2:0] pin_mode_config,
  input wire [5:0] pin_is_gpio_out,
  output wire [5:0] modem_out,
  output wire [5:0] modem_out_oe,
  input wire [1:0] mode_config,
  output wire loopback_en,
  output wire [1:0] loopback_variant,
  // Device level.
  output wire irq,
  output wire timers_irq_request,
  output wire modem_irq_request,
  output wire soft_reset,
  output reg power_down,
  // Transmit machine side.
  output reg tx_enable,
  output reg tx_machine_flush,
  input wire tx_char_busy,
  output wire tx_valid,
  input wire tx_ready,
  output wire [10:0] tx_entry,
  // Receive machine side.
  output reg rx_enable,
  output reg rx_machine_flush,
  input wire rx_valid,
  output wire rx_ready,
  input wire [7:0] rx_char,
  input wire [7:0] rx_char_flags,
  output reg rx_dropped
);
  // ------
  // Bus strobes
  // ------
  reg rd_q;
  reg wr_q;
  wire rd_act;
  wire wr_act;
  wire rd_go;
  wire wr_go;
  assign rd_act = ~cs_n & ~rd_n;
  assign wr_act = ~cs_n & ~wr_n;
  // Side effects fire once, on the first clock of a strobe.
  assign rd_go = rd_act & ~rd_q;
  assign wr_go = wr_act & ~wr_q;
  assign rdata_oe = rd_act;
  wire wr_dev = wr_go & (addr == `ACSR_DEVICE_COMMAND);
  wire wr_txc = wr_go & (addr == `ACSR_TRANSMITTER_COMMAND);
  wire wr_rxc = wr_go & (addr == `ACSR_RECEIVER_COMMAND);
  wire wr_tmr = wr_go & (addr == `ACSR_TIMER_GATE_AND_START);
  wire rd_msr = rd_go & (addr == `ACSR_MODEM_PIN_REPORT);
  wire rd_rxb = rd_go & (addr == `ACSR_RECEIVE_BYTE);

  // ------
  // Software reset
  // ------
  reg [2:0] software_total_reset_cnt;
  wire software_total_reset;
  assign software_total_reset = (software_total_reset_cnt != 3'h0);
  assign soft_reset = software_total_reset;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      software_total_reset_cnt <= 3'h0;
    end else if (wr_dev & wdata[`ACSR_SOFTWARE_TOTAL_RESET]) begin
      software_total_reset_cnt <= `ACSR_SOFT_RESET_CLOCKS; // RQ10
    end else if (software_total_reset) begin
      software_total_reset_cnt <= software_total_reset_cnt - 3'h1;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= rd_act;
      wr_q <= wr_act;
    end
  end

  // ------
  // Timer status
  // ------
  reg timer_a_expired;
  reg timer_b_expired;
  wire wipe = wr_dev & wdata[`ACSR_STATUS_WIPE_CMD];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_a_gate <= 1'b0;
      timer_b_gate <= 1'b0;
      timer_a_start <= 1'b0;
      timer_b_start <= 1'b0;
      timer_a_expired <= 1'b0;
      timer_b_expired <= 1'b0;
    end else if (software_total_reset) begin
      timer_a_gate <= 1'b0;
      timer_b_gate <= 1'b0;
      timer_a_start <= 1'b0;
      timer_b_start <= 1'b0;
      timer_a_expired <= 1'b0;
      timer_b_expired <= 1'b0;
    end else begin
      // Gates persist; starts are one-clock pulses.
      if (wr_tmr & ~timer_a_baud_mode) begin
        timer_a_gate <= wdata[`ACSR_TIMER_A_GATE]; // RQ17
      end
      if (wr_tmr & ~timer_b_baud_mode) begin
        timer_b_gate <= wdata[`ACSR_TIMER_B_GATE]; // RQ17
      end
      timer_a_start <= wr_tmr & ~timer_a_baud_mode & wdata[`ACSR_TIMER_A_START_CMD]; // RQ18
      timer_b_start <= wr_tmr & ~timer_b_baud_mode & wdata[`ACSR_TIMER_B_START_CMD]; // RQ18
      timer_a_expired <= timer_a_tc | (timer_a_expired & ~wipe); // RQ1 RQ12
      timer_b_expired <= timer_b_tc | (timer_b_expired & ~wipe); // RQ1 RQ12
    end
  end
  assign timers_irq_request = timer_a_expired | timer_b_expired; // RQ1 RQ2

  // ------
  // Modem pin status
  // ------
  reg cts_q;
  reg dcd_q;
  reg dsr_q;
  reg ri_q;
  reg clear_to_send_changed;
  reg set_ready_changed;
  reg ring_falling_seen;
  reg carrier_detect_changed;
  wire clr_delta = rd_msr | wipe; // RQ4 RQ12
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cts_q <= 1'b1;
      dcd_q <= 1'b1;
      dsr_q <= 1'b1;
      ri_q <= 1'b1;
      clear_to_send_changed <= 1'b0;
      set_ready_changed <= 1'b0;
      ring_falling_seen <= 1'b0;
      carrier_detect_changed <= 1'b0;
    end else begin
      cts_q <= cts_n;
      dcd_q <= dcd_n;
      dsr_q <= dsr_n;
      ri_q <= ri_n;
      if (software_total_reset) begin
        clear_to_send_changed <= 1'b0;
        set_ready_changed <= 1'b0;
        ring_falling_seen <= 1'b0;
        carrier_detect_changed <= 1'b0;
      end else begin
        // A change in the clearing cycle still sets the bit.
        clear_to_send_changed <= (cts_n ^ cts_q) | (clear_to_send_changed & ~clr_delta); // RQ6
        set_ready_changed <= ((dsr_n ^ dsr_q) & pin_mode_config[2]) |
                             (set_ready_changed & ~clr_delta); // RQ6
        ring_falling_seen <= (ri_q & ~ri_n & pin_mode_config[1]) |
                             (ring_falling_seen & ~clr_delta); // RQ7
        carrier_detect_changed <= ((dcd_n ^ dcd_q) & pin_mode_config[0]) |
                                  (carrier_detect_changed & ~clr_delta); // RQ6
      end
    end
  end
  wire carrier_detect_inverted = pin_mode_config[0] & ~dcd_n; // RQ5
  wire ring_indicator_inverted = pin_mode_config[1] & ~ri_n; // RQ5
  wire set_ready_inverted = pin_mode_config[2] & ~dsr_n; // RQ5
  wire [7:0] modem_pin_report = {1'b0, set_ready_inverted, ring_indicator_inverted,
    carrier_detect_inverted, carrier_detect_changed, ring_falling_seen,
    set_ready_changed, clear_to_send_changed};
  assign modem_irq_request = |modem_pin_report[3:0]; // RQ3

  // ------
  // Interrupt output and device commands
  // ------
  reg [1:0] ack_cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_cnt <= 2'h0;
      power_down <= 1'b0;
    end else if (software_total_reset) begin
      ack_cnt <= 2'h0;
      power_down <= 1'b0;
    end else begin
      if (wr_dev & wdata[`ACSR_IRQ_ACKNOWLEDGE_CMD]) begin
        ack_cnt <= `ACSR_IRQ_ACK_CLOCKS; // RQ11
      end else if (ack_cnt != 2'h0) begin
        ack_cnt <= ack_cnt - 2'h1;
      end
      if (wr_dev & wdata[`ACSR_POWER_DOWN_CMD]) begin
        power_down <= 1'b1; // RQ12
      end
    end
  end
  assign irq = (timers_irq_request | modem_irq_request) & (ack_cnt == 2'h0) & ~software_total_reset; // RQ11

  // ------
  // Modem outputs
  // ------
  reg [7:0] modem_output_control;
  reg [2:0] transmit_extra_bits;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_output_control <= `ACSR_MODEM_OUTPUT_RESET;
      transmit_extra_bits <= `ACSR_EXTRA_BITS_RESET;
    end else if (software_total_reset) begin
      modem_output_control <= `ACSR_MODEM_OUTPUT_RESET;
      transmit_extra_bits <= `ACSR_EXTRA_BITS_RESET;
    end else if (wr_go) begin
      if (addr == `ACSR_MODEM_OUTPUT_CONTROL) begin
        modem_output_control <= wdata;
      end
      if (addr == `ACSR_TRANSMIT_EXTRA_BITS) begin
        transmit_extra_bits <= wdata[2:0]; // RQ22
      end
    end
  end
  // Pins not configured as general outputs are left undriven here.
  assign modem_out = {1'b0, ~{modem_output_control[`ACSR_GENERAL_OUTPUT_ZERO],
    modem_output_control[3:0]}}; // RQ19
  assign modem_out_oe = pin_is_gpio_out; // RQ19
  assign loopback_en = modem_output_control[`ACSR_LOOPBACK_SELECT_BIT]; // RQ20
  assign loopback_variant = mode_config; // RQ20

  // ------
  // Transmit control and queue
  // ------
  reg tx_stop_pending;
  wire tx_flush_q = wr_txc & wdata[`ACSR_FLUSH_TX_QUEUE_CMD];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_enable <= 1'b0;
      tx_stop_pending <= 1'b0;
      tx_machine_flush <= 1'b0;
    end else if (software_total_reset) begin
      tx_enable <= 1'b0;
      tx_stop_pending <= 1'b0;
      tx_machine_flush <= 1'b0;
    end else begin
      tx_machine_flush <= wr_txc & wdata[`ACSR_FLUSH_TRANSMITTER_CMD]; // RQ13
      if (wr_txc & (wdata[`ACSR_FLUSH_TRANSMITTER_CMD] | wdata[`ACSR_TRANSMIT_ENABLE_CMD])) begin
        tx_enable <= 1'b1; // RQ13
        tx_stop_pending <= 1'b0;
      end else if (wr_txc & wdata[`ACSR_TRANSMIT_DISABLE_CMD]) begin
        tx_stop_pending <= 1'b1; // RQ14
      end else if (tx_stop_pending & ~tx_char_busy) begin
        tx_enable <= 1'b0; // RQ14
        tx_stop_pending <= 1'b0;
      end
    end
  end
  wire tx_push = wr_go & (addr == `ACSR_TRANSMIT_BYTE); // RQ21
  wire tx_in_ready;
  wire tx_out_valid;
  // Writes into a full queue are dropped, as the host has no wait line.
  acsr_fifo #(.WIDTH(11), .DEPTH(TX_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(tx_flush_q | software_total_reset), // RQ13
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data({transmit_extra_bits, wdata}), // RQ21
    .out_valid(tx_out_valid),
    .out_ready(tx_ready & tx_enable),
    .out_data(tx_entry),
    .level()
  );
  assign tx_valid = tx_out_valid & tx_enable;

  // ------
  // Receive control and queue
  // ------
  reg rx_locked;
  wire rx_flush_q = wr_rxc & wdata[`ACSR_FLUSH_RX_QUEUE_CMD];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_enable <= 1'b0;
      rx_locked <= 1'b0;
      rx_machine_flush <= 1'b0;
      rx_dropped <= 1'b0;
    end else if (software_total_reset) begin
      rx_enable <= 1'b0;
      rx_locked <= 1'b0;
      rx_machine_flush <= 1'b0;
      rx_dropped <= 1'b0;
    end else begin
      rx_machine_flush <= wr_rxc & wdata[`ACSR_FLUSH_RECEIVER_CMD]; // RQ15
      rx_dropped <= rx_valid & rx_locked; // RQ16
      if (wr_rxc & (wdata[`ACSR_FLUSH_RECEIVER_CMD] | wdata[`ACSR_RECEIVE_ENABLE_CMD])) begin
        rx_enable <= 1'b1; // RQ15
      end else if (wr_rxc & wdata[`ACSR_RECEIVE_DISABLE_CMD]) begin
        rx_enable <= 1'b0; // RQ15
      end
      if (wr_rxc & (wdata[`ACSR_FLUSH_RECEIVER_CMD] | wdata[`ACSR_UNLOCK_RX_QUEUE_CMD])) begin
        rx_locked <= 1'b0; // RQ15 RQ16
      end else if (wr_rxc & wdata[`ACSR_LOCK_RX_QUEUE_CMD]) begin
        rx_locked <= 1'b1; // RQ16
      end
    end
  end
  wire rx_in_ready;
  wire rx_out_valid;
  wire [15:0] rx_out_data;
  reg [7:0] receive_byte;
  reg [7:0] receive_char_flags;
  reg rx_held;
  wire rx_load = rx_out_valid & (~rx_held | rd_rxb); // RQ23
  // A locked queue still accepts from the receiver and discards the character.
  assign rx_ready = rx_in_ready | rx_locked;
  acsr_fifo #(.WIDTH(16), .DEPTH(RX_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(rx_flush_q | software_total_reset), // RQ15
    .in_valid(rx_valid & ~rx_locked), // RQ16
    .in_ready(rx_in_ready),
    .in_data({rx_char_flags, rx_char}),
    .out_valid(rx_out_valid),
    .out_ready(rx_load),
    .out_data(rx_out_data),
    .level()
  );
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      receive_byte <= 8'h00;
      receive_char_flags <= 8'h00;
      rx_held <= 1'b0;
    end else if (software_total_reset | rx_flush_q) begin
      receive_byte <= 8'h00;
      receive_char_flags <= 8'h00;
      rx_held <= 1'b0;
    end else if (rx_load) begin
      receive_byte <= rx_out_data[7:0]; // RQ23
      receive_char_flags <= rx_out_data[15:8]; // RQ24
      rx_held <= 1'b1;
    end else if (rd_rxb) begin
      rx_held <= 1'b0;
    end
  end

  // ------
  // Read data
  // ------
  reg [7:0] next_rdata;
  always @* begin
    case (addr)
      `ACSR_TIMER_STATE_REPORT: next_rdata = {4'h0, timer_b_gate, timer_a_gate,
        timer_b_expired, timer_a_expired}; // RQ2
      `ACSR_MODEM_PIN_REPORT: next_rdata = modem_pin_report;
      `ACSR_MODEM_OUTPUT_CONTROL: next_rdata = modem_output_control;
      `ACSR_TRANSMIT_EXTRA_BITS: next_rdata = {5'h00, transmit_extra_bits};
      `ACSR_RECEIVE_BYTE: next_rdata = receive_byte;
      `ACSR_RECEIVE_CHAR_FLAGS: next_rdata = receive_char_flags;
      `ACSR_GROUP_STATUS: next_rdata = {6'h00, modem_irq_request, timers_irq_request};
      // Command registers and the transmit byte are write-only and read zero.
      default: next_rdata = 8'h00; // RQ8
    endcase
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_go) begin
      rdata <= next_rdata;
    end
  end
endmodule

// ===== verification/acsr_regs_chk.sv
// Concurrent checks on the ports of the serial register block.
`timescale 1ns/1ns
`include "acsr_map.vh"
module acsr_regs_chk (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire wr_n,
  input wire [`ACSR_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire timer_a_baud_mode,
  input wire timer_b_baud_mode,
  input wire timer_a_tc,
  input wire timer_a_start,
  input wire timer_b_gate,
  input wire [5:0] pin_is_gpio_out,
  input wire [5:0] modem_out,
  input wire [5:0] modem_out_oe,
  input wire [1:0] mode_config,
  input wire [1:0] loopback_variant,
  input wire irq,
  input wire timers_irq_request,
  input wire soft_reset,
  input wire tx_enable,
  input wire tx_char_busy
);
  reg wr_seen;
  reg [7:0] wdata_q;
  // A held strobe acts once, so only its first cycle counts as a write.
  wire wr_take = !cs_n && !wr_n && !wr_seen;
  wire dev_wr = wr_take && addr == `ACSR_DEVICE_COMMAND;
  wire tmr_wr = wr_take && addr == `ACSR_TIMER_GATE_AND_START;
  wire mout_wr = wr_take && addr == `ACSR_MODEM_OUTPUT_CONTROL;
  wire tx_wr = wr_take && addr == `ACSR_TRANSMITTER_COMMAND;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_seen <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      wr_seen <= !cs_n && !wr_n;
      wdata_q <= wdata;
    end
  end
  // ------
  // Checks
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ack_cmd;
    dev_wr && wdata[`ACSR_IRQ_ACKNOWLEDGE_CMD];
  endsequence
  sequence s_software_total_reset_hold;
    soft_reset [*4] ##1 !soft_reset;
  endsequence
  chk_ack_irq_low: assert property (s_ack_cmd |=> !irq [*2])
    else $error("irq during ack");
  chk_software_total_reset_four: assert property (dev_wr && wdata[0] |=> s_software_total_reset_hold)
    else $error("software_total_reset length");
  chk_start_pulse: assert property (tmr_wr && wdata[2] && !timer_a_baud_mode
    |=> timer_a_start ##1 !timer_a_start) else $error("start pulse");
  chk_tc_expired: assert property (timer_a_tc && !soft_reset && !wr_take
    |=> timers_irq_request) else $error("tc lost");
  chk_gate_baud: assert property (tmr_wr && timer_b_baud_mode && !soft_reset
    |=> timer_b_gate == $past(timer_b_gate)) else $error("baud gate moved");
  chk_out_invert: assert property (mout_wr && !soft_reset
    |=> modem_out == {1'b0, ~wdata_q[5], ~wdata_q[3:0]}) else $error("modem out wrong");
  chk_oe_variant: assert property (modem_out_oe == pin_is_gpio_out
    && loopback_variant == mode_config) else $error("oe or variant");
  chk_tx_finish: assert property (tx_wr && wdata[3] && tx_enable && tx_char_busy
    |=> tx_enable) else $error("tx stopped early");
  chk_tx_stop: assert property (tx_wr && wdata[3] && !tx_char_busy && !soft_reset
    |-> ##[1:2] !tx_enable) else $error("tx disable ignored");
endmodule
bind acsr_regs acsr_regs_chk i_chk (.clk, .rst, .cs_n, .wr_n, .addr, .wdata,
  .timer_a_baud_mode, .timer_b_baud_mode, .timer_a_tc, .timer_a_start, .timer_b_gate,
  .pin_is_gpio_out, .modem_out, .modem_out_oe, .mode_config, .loopback_variant, .irq,
  .timers_irq_request, .soft_reset, .tx_enable, .tx_char_busy);

// ===== verification/acsr_host_model.sv
// Host-side model that drives the parallel register strobes.
`timescale 1ns/1ns
module acsr_host_model (
  input wire clk,
  input wire [7:0] rdata,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] addr,
  output logic [7:0] wdata
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
  end
  // Strobes change at the falling edge and stand across one rising edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      cs_n = 1'b0;
      wr_n = 1'b0;
      @(negedge clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
      // Released data is inverted so that stale use shows.
      wdata = ~d;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      @(negedge clk);
      d = rdata;
      cs_n = 1'b1;
      rd_n = 1'b1;
    end
  endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the serial register block.
`timescale 1ns/1ns
`include "acsr_map.vh"
module tb_top;
  typedef struct packed {logic [7:0] val; logic [5:0] pins;} acsr_row_t;
  localparam logic [3:0] a_tmr_rep = `ACSR_TIMER_STATE_REPORT,
    a_pin_rep = `ACSR_MODEM_PIN_REPORT, a_dev = `ACSR_DEVICE_COMMAND,
    a_txc = `ACSR_TRANSMITTER_COMMAND, a_rxc = `ACSR_RECEIVER_COMMAND,
    a_tmr = `ACSR_TIMER_GATE_AND_START, a_mout = `ACSR_MODEM_OUTPUT_CONTROL,
    a_txb = `ACSR_TRANSMIT_BYTE, a_txx = `ACSR_TRANSMIT_EXTRA_BITS,
    a_rxb = `ACSR_RECEIVE_BYTE, a_rxfl = `ACSR_RECEIVE_CHAR_FLAGS, a_grp = `ACSR_GROUP_STATUS;
  acsr_row_t rows [7] = '{'{8'h01, 6'h1E}, '{8'h02, 6'h1D}, '{8'h04, 6'h1B},
    '{8'h08, 6'h17}, '{8'h20, 6'h0F}, '{8'h10, 6'h1F}, '{8'h3F, 6'h00}};
  logic clk;
  logic rst = 1'b1;
  logic timer_a_baud_mode = 1'b0, timer_b_baud_mode = 1'b0;
  logic timer_a_tc = 1'b0, timer_b_tc = 1'b0;
  logic cts_n = 1'b1, dcd_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1;
  logic [2:0] pin_mode_config = 3'h7;
  logic [5:0] pin_is_gpio_out = 6'h3F;
  logic [1:0] mode_config = 2'h2;
  logic tx_char_busy = 1'b0, tx_ready = 1'b0, rx_valid = 1'b0;
  logic [7:0] rx_char = 8'h00, rx_char_flags = 8'h00;
  wire cs_n, rd_n, wr_n, rdata_oe, timer_a_gate, timer_b_gate, timer_a_start, timer_b_start;
  wire [3:0] addr;
  wire [7:0] wdata, rdata;
  wire [5:0] modem_out, modem_out_oe;
  wire [1:0] loopback_variant;
  wire loopback_en, irq, timers_irq_request, modem_irq_request, soft_reset, power_down;
  wire tx_enable, tx_machine_flush, tx_valid, rx_enable, rx_machine_flush, rx_ready;
  wire rx_dropped;
  wire [10:0] tx_entry;
  logic [2:0] seen = 3'h0;
  logic [7:0] d;
  int err_count = 0, n_compared = 0, k, n;
  acsr_regs i_dut (.clk, .rst, .cs_n, .rd_n, .wr_n, .addr, .wdata, .rdata, .rdata_oe,
    .timer_a_baud_mode, .timer_b_baud_mode, .timer_a_tc, .timer_b_tc, .timer_a_gate,
    .timer_b_gate, .timer_a_start, .timer_b_start, .cts_n, .dcd_n, .dsr_n, .ri_n,
    .pin_mode_config, .pin_is_gpio_out, .modem_out, .modem_out_oe, .mode_config,
    .loopback_en, .loopback_variant, .irq, .timers_irq_request, .modem_irq_request,
    .soft_reset, .power_down, .tx_enable, .tx_machine_flush, .tx_char_busy, .tx_valid,
    .tx_ready, .tx_entry, .rx_enable, .rx_machine_flush, .rx_valid, .rx_ready, .rx_char,
    .rx_char_flags, .rx_dropped);
  acsr_host_model i_host (.clk, .rdata, .cs_n, .rd_n, .wr_n, .addr, .wdata);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pulses are latched so a check after the fact still sees them.
  always @(posedge clk) seen <= seen | {rx_dropped, rx_machine_flush, tx_machine_flush};
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic push(input logic [7:0] c, input logic [7:0] f);
    @(negedge clk);
    rx_char = c;
    rx_char_flags = f;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_char = ~c;
    rx_char_flags = ~f;
  endtask
  initial begin
    #300000;
    err_count++;
    tally_and_finish;
  end
  // ------
  // Stimulus
  // ------
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check(modem_out, 6'h1F);
    check({irq, tx_valid, rx_ready, rdata_oe}, 4'h2);
    foreach (rows[i]) begin
      i_host.wr(a_mout, rows[i].val);
      i_host.rd(a_mout, d);
      check(d, rows[i].val);
      check(modem_out, rows[i].pins);
      check(loopback_en, rows[i].val[4]);
    end
    i_host.rd(a_dev, d);
    check(d, 8'h00);
    i_host.rd(4'hF, d);
    check(d, 8'h00);
    i_host.wr(a_mout, 8'h00);
    i_host.wr(a_tmr, 8'h01);
    settle;
    check(irq, 1'b0);
    i_host.rd(a_tmr_rep, d);
    check(d, 8'h04);
    i_host.wr(a_tmr, 8'h05);
    check(timer_a_gate, 1'b1);
    timer_a_tc = 1'b1;
    @(negedge clk);
    timer_a_tc = 1'b0;
    @(negedge clk);
    check({timers_irq_request, irq}, 2'h3);
    i_host.rd(a_tmr_rep, d);
    check(d, 8'h05);
    i_host.rd(a_grp, d);
    check(d, 8'h01);
    i_host.wr(a_dev, 8'h02);
    check(irq, 1'b0);
    repeat (3) @(negedge clk);
    check(irq, 1'b1);
    i_host.wr(a_dev, 8'h04);
    @(negedge clk);
    check(timers_irq_request, 1'b0);
    timer_b_baud_mode = 1'b1;
    i_host.wr(a_tmr, 8'h03);
    check(timer_b_gate, 1'b0);
    timer_b_baud_mode = 1'b0;
    dcd_n = 1'b0;
    settle;
    check(modem_irq_request, 1'b1);
    i_host.rd(a_pin_rep, d);
    check(d, 8'h18);
    i_host.rd(a_pin_rep, d);
    check(d, 8'h10);
    ri_n = 1'b0;
    settle;
    i_host.rd(a_pin_rep, d);
    check(d, 8'h34);
    ri_n = 1'b1;
    settle;
    i_host.rd(a_pin_rep, d);
    check(d, 8'h10);
    cts_n = 1'b0;
    settle;
    i_host.rd(a_pin_rep, d);
    check(d, 8'h11);
    pin_mode_config = 3'h3;
    dsr_n = 1'b0;
    settle;
    i_host.rd(a_pin_rep, d);
    check(d, 8'h10);
    dcd_n = 1'b1;
    settle;
    i_host.wr(a_dev, 8'h04);
    i_host.rd(a_pin_rep, d);
    check(d, 8'h00);
    i_host.wr(a_txx, 8'h05);
    i_host.rd(a_txx, d);
    check(d, 8'h05);
    i_host.wr(a_txc, 8'h04);
    check(tx_enable, 1'b1);
    // One byte more than the queue holds; the last is dropped.
    for (k = 0; k < 33; k++) i_host.wr(a_txb, k[7:0]);
    check({tx_valid, tx_entry}, 12'hD00);
    tx_ready = 1'b1;
    n = 0;
    repeat (40) begin
      if (tx_valid === 1'b1) begin
        check(tx_entry, {3'h5, n[7:0]});
        n++;
      end
      @(negedge clk);
    end
    check(n[15:0], 16'h0020);
    tx_ready = 1'b0;
    i_host.wr(a_txb, 8'h11);
    i_host.wr(a_txc, 8'h02);
    @(negedge clk);
    check(tx_valid, 1'b0);
    tx_char_busy = 1'b1;
    i_host.wr(a_txc, 8'h08);
    settle;
    check(tx_enable, 1'b1);
    tx_char_busy = 1'b0;
    settle;
    check(tx_enable, 1'b0);
    i_host.wr(a_txc, 8'h01);
    settle;
    check({tx_enable, seen[0]}, 2'h3);
    i_host.wr(a_txc, 8'h08);
    settle;
    check(tx_enable, 1'b0);
    i_host.wr(a_rxc, 8'h01);
    check(rx_enable, 1'b1);
    push(8'h3C, 8'h81);
    push(8'h42, 8'h02);
    settle;
    i_host.rd(a_rxfl, d);
    check(d, 8'h81);
    i_host.rd(a_rxb, d);
    check(d, 8'h3C);
    i_host.rd(a_rxfl, d);
    check(d, 8'h02);
    i_host.rd(a_rxb, d);
    check(d, 8'h42);
    i_host.wr(a_rxc, 8'h10);
    push(8'h77, 8'h00);
    settle;
    check(seen[2], 1'b1);
    i_host.wr(a_rxc, 8'h20);
    push(8'h11, 8'h00);
    settle;
    i_host.rd(a_rxb, d);
    check(d, 8'h11);
    i_host.wr(a_rxc, 8'h02);
    check(rx_enable, 1'b0);
    i_host.wr(a_rxc, 8'h04);
    settle;
    check({rx_enable, seen[1]}, 2'h3);
    i_host.wr(a_dev, 8'h08);
    check(power_down, 1'b1);
    i_host.wr(a_mout, 8'h01);
    i_host.wr(a_dev, 8'h01);
    repeat (6) @(negedge clk);
    check({modem_out, power_down, rx_enable}, 8'h7C);
    tally_and_finish;
  end
endmodule
